// [hdl/spisd_top.sv]
// Strobed register access was decided locally.
`timescale 1ns/1ps
`include "spisd_defines.svh"

// Function
// R1 - Select low as master sets fault flag
// R2 - Fault clears after status access, control write
// R3 - Software writes zero to status bit three
// R4 - Output disable stops driving serial data output
// R5 - Software select source ignores the select pin
// R6 - Soft select zero selects, one deselects
// R7 - Master data write starts one byte exchange
// R8 - Received byte copied to buffer at completion
// R9 - Data writes dropped while done, until status read
// R10 - Accepted write goes straight into shift register; while busy it is not loaded and only sets the collision flag
// R11 - Data read returns receive buffer only
// R12 - Defined reset values for all registers
// R13 - Done flag set, cleared by status-data sequence
// R14 - Fault clears enable and master bits
// R15 - Enabled flags raise the single interrupt
// R16 - Overrun set if done still set; status read clears
// R17 - Bytes shift most significant bit first
module spisd_top (
  // Clock and reset.
  input  wire logic               clock,
  input  wire logic               rstn,
  // Register port.
  input  wire logic [7:0]         addr,
  input  wire spisd_pkg::spisd_byte_t wdata,
  input  wire logic               wr,
  input  wire logic               rd,
  output spisd_pkg::spisd_byte_t  rdata,
  // Serial pins.
  input  wire logic               sck_in,
  output logic                    sck_out,
  output logic                    sck_oe,
  input  wire logic               mosi_in,
  output logic                    mosi_out,
  output logic                    mosi_oe,
  input  wire logic               miso_in,
  output logic                    miso_out,
  output logic                    miso_oe,
  input  wire logic               ss_in_n,
  // Interrupt.
  output logic                    irq
);
  import spisd_pkg::*;

  // ----------------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------------
  spisd_link_if link ();

  logic [3:0]  sync_a_ff;
  logic [3:0]  sync_b_ff;
  spisd_byte_t ctrl_ff;
  spisd_byte_t rxbuf_ff;
  spisd_byte_t rdata_ff;
  logic        done_ff;
  logic        write_collision_flag_ff;
  logic        ovr_ff;
  logic        fault_ff;
  logic        sod_ff;
  logic        ssm_ff;
  logic        ssi_ff;
  logic        csr_seen_ff;
  logic        done_rd_ff;
  logic        fault_seen_ff;
  logic [2:0]  irq_st_ff;
  logic [2:0]  irq_mk_ff;
  logic        irq_ff;
  logic        sck_oe_ff;
  logic        mosi_oe_ff;
  logic        miso_oe_ff;
  logic        ss_pin_n;
  logic        ss_int_n;
  logic        csr_acc;
  logic        csr_rd;
  logic        dat_acc;
  logic        dat_rd;
  logic        dat_wr_ok;
  logic        ctrl_wr;
  logic        write_collision_flag_ev;
  logic        fault_ev;
  logic        ovr_ev;
  logic        xfer;
  logic [2:0]  events;
  logic [6:0]  half;

  // ----------------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------------

  // Two flip-flops for each pin input: select, clock, mosi, miso.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sync_a_ff <= 4'hf;
      sync_b_ff <= 4'hf;
    end else begin
      sync_a_ff <= {ss_in_n, sck_in, mosi_in, miso_in};
      sync_b_ff <= sync_a_ff;
    end
  end

  // Internal select comes from the soft level or from the pin, low means selected.
  assign ss_pin_n = sync_b_ff[3];
  assign ss_int_n = ssm_ff ? ssi_ff : ss_pin_n; // R5 R6

  // ----------------------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------------------

  // Strobes qualified by address.
  assign csr_acc   = (wr || rd) && addr == `SPISD_ADR_CSR;
  assign csr_rd    = rd && addr == `SPISD_ADR_CSR;
  assign dat_acc   = (wr || rd) && addr == `SPISD_ADR_DATA;
  assign dat_rd    = rd && addr == `SPISD_ADR_DATA;
  assign ctrl_wr   = wr && addr == `SPISD_ADR_CTRL;
  assign dat_wr_ok = wr && addr == `SPISD_ADR_DATA && !(done_ff && !done_rd_ff); // R9

  // Hardware events.
  assign xfer     = link.done;
  assign write_collision_flag_ev  = dat_wr_ok && link.busy;
  assign fault_ev = ctrl_ff[`SPISD_CTRL_MS] && ctrl_ff[`SPISD_CTRL_EN] && !ss_int_n; // R1
  assign ovr_ev   = xfer && done_ff; // R16

  // Serial clock divider chosen from the three rate bits.
  always_comb begin
    case ({ctrl_ff[`SPISD_CTRL_DIV], ctrl_ff[`SPISD_CTRL_SPR1], ctrl_ff[`SPISD_CTRL_SPR0]})
      3'h4:    half = `SPISD_HALF_4;
      3'h0:    half = `SPISD_HALF_8;
      3'h1:    half = `SPISD_HALF_16;
      3'h6:    half = `SPISD_HALF_32;
      3'h2:    half = `SPISD_HALF_64;
      3'h3:    half = `SPISD_HALF_128;
      default: half = `SPISD_HALF_128;
    endcase
  end

  // ----------------------------------------------------------------------------
  // Shift engine
  // ----------------------------------------------------------------------------

  // Controls toward the engine; a write when idle loads the byte at once.
  assign link.master = ctrl_ff[`SPISD_CTRL_MS];
  assign link.enable = ctrl_ff[`SPISD_CTRL_EN];
  assign link.cpol   = ctrl_ff[`SPISD_CTRL_CPOL];
  assign link.cpha   = ctrl_ff[`SPISD_CTRL_CPHA];
  assign link.half   = half;
  assign link.load   = dat_wr_ok && !link.busy; // R10
  assign link.start  = link.load && ctrl_ff[`SPISD_CTRL_MS] && ctrl_ff[`SPISD_CTRL_EN]; // R7
  assign link.tx     = wdata;
  assign link.ss_act = !ss_int_n;
  assign link.sck_s  = sync_b_ff[2];
  assign link.din    = ctrl_ff[`SPISD_CTRL_MS] ? sync_b_ff[0] : sync_b_ff[1];

  spisd_shift u_shift (
    .clock (clock),
    .rstn  (rstn),
    .bus   (link)
  );

  // ----------------------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------------------

  // A fault drops enable and master; otherwise software writes the whole byte.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrl_ff <= `SPISD_RST_BYTE; // R12
    end else if (fault_ev) begin
      ctrl_ff[`SPISD_CTRL_EN] <= 1'b0; // R14
      ctrl_ff[`SPISD_CTRL_MS] <= 1'b0; // R14
    end else if (ctrl_wr) begin
      ctrl_ff <= wdata;
    end
  end

  // Software bits of the status register; the reserved bit is not stored.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sod_ff <= 1'b0; // R12
      ssm_ff <= 1'b0;
      ssi_ff <= 1'b0;
    end else if (wr && addr == `SPISD_ADR_CSR) begin
      sod_ff <= wdata[2];
      ssm_ff <= wdata[1];
      ssi_ff <= wdata[0];
    end
  end

  // ----------------------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------------------

  // Record of status accesses that arm the clearing sequences.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      csr_seen_ff   <= 1'b0;
      done_rd_ff    <= 1'b0;
      fault_seen_ff <= 1'b0;
    end else begin
      if (csr_acc) csr_seen_ff <= 1'b1;
      else if (dat_acc) csr_seen_ff <= 1'b0;
      if (csr_rd && done_ff) done_rd_ff <= 1'b1;
      else if (!done_ff) done_rd_ff <= 1'b0;
      if (csr_acc && fault_ff) fault_seen_ff <= 1'b1;
      else if (!fault_ff) fault_seen_ff <= 1'b0;
    end
  end

  // Done and collision flags: set wins over the clearing sequence.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      done_ff <= 1'b0;
      write_collision_flag_ff <= 1'b0;
    end else begin
      if (xfer) done_ff <= 1'b1; // R13
      else if (csr_seen_ff && dat_acc) done_ff <= 1'b0; // R13
      if (write_collision_flag_ev) write_collision_flag_ff <= 1'b1;
      else if (csr_seen_ff && dat_acc) write_collision_flag_ff <= 1'b0;
    end
  end

  // Overrun is set by a byte landing on a pending one, cleared by a status read.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ovr_ff <= 1'b0;
    end else if (ovr_ev) begin
      ovr_ff <= 1'b1; // R16
    end else if (csr_rd) begin
      ovr_ff <= 1'b0; // R16
    end
  end

  // Fault flag clears after a status access and then a control write.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      fault_ff <= 1'b0;
    end else if (fault_ev) begin
      fault_ff <= 1'b1; // R1
    end else if (fault_seen_ff && ctrl_wr) begin
      fault_ff <= 1'b0; // R2
    end
  end

  // Receive buffer takes the byte as the done flag rises; an overrun keeps the old one.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rxbuf_ff <= `SPISD_RST_BYTE;
    end else if (xfer && !done_ff) begin
      rxbuf_ff <= link.rx; // R8
    end
  end

  // ----------------------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------------------
  assign events = {ovr_ev, fault_ev, xfer};

  // Sticky events with write-one-to-clear, set wins; mask of the same layout.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      irq_st_ff <= 3'h0;
      irq_mk_ff <= `SPISD_RST_IRQMK;
    end else begin
      if (wr && addr == `SPISD_ADR_IRQST) irq_st_ff <= (irq_st_ff & ~wdata[2:0]) | events;
      else irq_st_ff <= irq_st_ff | events;
      if (wr && addr == `SPISD_ADR_IRQMK) irq_mk_ff <= wdata[2:0];
    end
  end

  // One level request, gated by the interrupt enable bit.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= ctrl_ff[`SPISD_CTRL_IE] && |(irq_st_ff & irq_mk_ff); // R15
    end
  end

  // ----------------------------------------------------------------------------
  // Read data and pin enables
  // ----------------------------------------------------------------------------

  // Read data stand one cycle after the strobe, zero otherwise and for unmapped addresses.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdata_ff <= `SPISD_RST_BYTE;
    end else if (rd) begin
      case (addr)
        `SPISD_ADR_DATA:  rdata_ff <= rxbuf_ff; // R11
        `SPISD_ADR_CTRL:  rdata_ff <= ctrl_ff;
        `SPISD_ADR_CSR:   rdata_ff <= {done_ff, write_collision_flag_ff, ovr_ff, fault_ff, 1'b0, sod_ff, ssm_ff, ssi_ff}; // R3
        `SPISD_ADR_IRQST: rdata_ff <= {5'h00, irq_st_ff};
        `SPISD_ADR_IRQMK: rdata_ff <= {5'h00, irq_mk_ff};
        default:          rdata_ff <= `SPISD_RST_BYTE;
      endcase
    end else begin
      rdata_ff <= `SPISD_RST_BYTE;
    end
  end

  // Output enables; the data output follows the mode and the disable bit.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sck_oe_ff  <= 1'b0;
      mosi_oe_ff <= 1'b0;
      miso_oe_ff <= 1'b0;
    end else begin
      sck_oe_ff  <= ctrl_ff[`SPISD_CTRL_EN] && ctrl_ff[`SPISD_CTRL_MS];
      mosi_oe_ff <= ctrl_ff[`SPISD_CTRL_EN] && ctrl_ff[`SPISD_CTRL_MS] && !sod_ff; // R4
      miso_oe_ff <= ctrl_ff[`SPISD_CTRL_EN] && !ctrl_ff[`SPISD_CTRL_MS] && !sod_ff; // R4
    end
  end

  assign rdata    = rdata_ff;
  assign sck_out  = link.sck_o;
  assign sck_oe   = sck_oe_ff;
  assign mosi_out = link.dout;
  assign mosi_oe  = mosi_oe_ff;
  assign miso_out = link.dout;
  assign miso_oe  = miso_oe_ff;
  assign irq      = irq_ff;

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  default clocking dcb @(posedge clock); endclocking
  default disable iff (!rstn);

  a_fault_set: assert property ( // R1
    (ctrl_ff[`SPISD_CTRL_MS] && ctrl_ff[`SPISD_CTRL_EN] && !ss_int_n) |=> fault_ff) else $error("fault not set");
  a_fault_clear: assert property ( // R2
    (fault_seen_ff && fault_ff && ctrl_wr && !fault_ev) |=> !fault_ff) else $error("fault not cleared");
  a_resv_zero: assert property ( // R3
    csr_rd |=> rdata[3] == 1'b0) else $error("reserved bit not zero");
  a_sod_quiet: assert property ( // R4
    sod_ff ##1 sod_ff |-> !mosi_oe && !miso_oe) else $error("output driven while disabled");
  a_soft_select: assert property ( // R6
    (ssm_ff && !ssi_ff && ctrl_ff[`SPISD_CTRL_MS] && ctrl_ff[`SPISD_CTRL_EN]) |=> fault_ff) else $error("soft select ignored");
  a_pin_ignored: assert property ( // R5
    (ssm_ff && ssi_ff) |-> !fault_ev) else $error("pin used under soft select");
  a_start_xfer: assert property ( // R7
    link.start |=> link.busy) else $error("write did not start a byte");
  a_done_copy: assert property ( // R8
    (xfer && !done_ff) |=> rxbuf_ff == $past(link.rx) && done_ff) else $error("buffer not loaded");
  a_write_block: assert property ( // R9
    (wr && addr == `SPISD_ADR_DATA && done_ff && !done_rd_ff) |-> !link.load) else $error("write not dropped");
  a_read_buf: assert property ( // R11
    dat_rd |=> rdata == $past(rxbuf_ff)) else $error("data read not from buffer");
  a_done_clear: assert property ( // R13
    (csr_seen_ff && dat_acc && !xfer) |=> !done_ff) else $error("done not cleared");
  a_fault_kill: assert property ( // R14
    $rose(fault_ff) |-> !ctrl_ff[`SPISD_CTRL_EN] && !ctrl_ff[`SPISD_CTRL_MS]) else $error("enable kept");
  a_irq_off: assert property ( // R15
    !ctrl_ff[`SPISD_CTRL_IE] |=> !irq) else $error("irq while disabled");
  a_ovr_set: assert property ( // R16
    (xfer && done_ff) |=> ovr_ff) else $error("overrun missed");

  c_done: cover property ($rose(done_ff));
  c_fault: cover property ($rose(fault_ff));
  c_ovr: cover property ($rose(ovr_ff));
  c_write_collision_flag: cover property ($rose(write_collision_flag_ff));

endmodule // spisd_top

// [common/spisd_defines.svh]
`ifndef SPISD_DEFINES_SVH
`define SPISD_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define SPISD_ADR_DATA  8'h21
`define SPISD_ADR_CTRL  8'h22
`define SPISD_ADR_CSR   8'h23
`define SPISD_ADR_IRQST 8'h24
`define SPISD_ADR_IRQMK 8'h25

// ----------------------------------------------------------------------------
// Field positions of serial_control
// ----------------------------------------------------------------------------
`define SPISD_CTRL_IE   7
`define SPISD_CTRL_EN   6
`define SPISD_CTRL_DIV  5
`define SPISD_CTRL_MS   4
`define SPISD_CTRL_CPOL 3
`define SPISD_CTRL_CPHA 2
`define SPISD_CTRL_SPR1 1
`define SPISD_CTRL_SPR0 0

// ----------------------------------------------------------------------------
// Interrupt event bit positions
// ----------------------------------------------------------------------------
`define SPISD_EV_DONE  0
`define SPISD_EV_FAULT 1
`define SPISD_EV_OVR   2

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SPISD_RST_BYTE  8'h00
`define SPISD_RST_IRQMK 3'h7

// ----------------------------------------------------------------------------
// Timing counts: clock cycles per half period of the serial clock, then last edge and last bit indices
// ----------------------------------------------------------------------------
`define SPISD_HALF_4   7'h02
`define SPISD_HALF_8   7'h04
`define SPISD_HALF_16  7'h08
`define SPISD_HALF_32  7'h10
`define SPISD_HALF_64  7'h20
`define SPISD_HALF_128 7'h40
`define SPISD_LAST_EDGE 5'h0f
`define SPISD_LAST_BIT  4'h7
// Longest master byte in clock cycles, with a small margin.
`define SPISD_BYTE_LIMIT 11'h410

`endif

// [common/spisd_pkg.sv]
package spisd_pkg;

  // Byte carried on the register port and the shift path.
  typedef logic [7:0] spisd_byte_t;

  // Shift engine states, Gray coded along idle, run, finish.
  typedef enum logic [1:0] {
    SPISD_IDLE = 2'b00,
    SPISD_RUN  = 2'b01,
    SPISD_FIN  = 2'b11
  } spisd_state_t;

endpackage

// [common/spisd_link_if.sv]
`timescale 1ns/1ps

interface spisd_link_if;
  import spisd_pkg::*;

  logic        master;
  logic        enable;
  logic        cpol;
  logic        cpha;
  logic [6:0]  half;
  logic        load;
  logic        start;
  spisd_byte_t tx;
  logic        ss_act;
  logic        sck_s;
  logic        din;
  logic        sck_o;
  logic        dout;
  logic        busy;
  logic        done;
  spisd_byte_t rx;

  // Register side drives the controls, the engine answers.
  modport ctl (output master, enable, cpol, cpha, half, load, start, tx, ss_act, sck_s, din,
               input  sck_o, dout, busy, done, rx);
  modport eng (input  master, enable, cpol, cpha, half, load, start, tx, ss_act, sck_s, din,
               output sck_o, dout, busy, done, rx);
endinterface

// [hdl/spisd_shift.sv]
`timescale 1ns/1ps
`include "spisd_defines.svh"

module spisd_shift (
  // Clock and reset.
  input wire logic clock,
  input wire logic rstn,
  // Link to the register side.
  spisd_link_if.eng bus
);
  import spisd_pkg::*;

  spisd_state_t state_ff;
  logic [6:0]   div_ff;
  logic [10:0]  age_ff;
  logic [4:0]   edge_ff;
  logic [3:0]   cnt_ff;
  logic         sck_ff;
  logic         sck_d_ff;
  logic         samp_ff;
  logic         sval_ff;
  logic         done_ff;
  spisd_byte_t  sh_ff;
  spisd_byte_t  rx_ff;
  logic         run;
  logic         m_tick;
  logic         m_lead;
  logic         s_chg;
  logic         s_lead;
  logic         samp;
  logic         shft;

  // Edge events, from the own divider as master, from the sampled pin as slave.
  assign run    = (state_ff == SPISD_RUN);
  assign m_tick = run && bus.master && (div_ff == bus.half - 7'h01);
  assign m_lead = m_tick && (sck_ff == bus.cpol);
  assign s_chg  = run && !bus.master && (bus.sck_s != sck_d_ff);
  assign s_lead = s_chg && (bus.sck_s != bus.cpol);
  assign samp   = bus.cpha ? ((m_tick && !m_lead) || (s_chg && !s_lead)) : (m_lead || s_lead);
  assign shft   = bus.cpha ? (m_lead || s_lead) : ((m_tick && !m_lead) || (s_chg && !s_lead));

  // Sequence: a master byte runs sixteen clock edges, a slave runs while selected.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_ff <= SPISD_IDLE;
    end else begin
      case (state_ff)
        SPISD_IDLE: if (bus.enable && (bus.master ? bus.start : bus.ss_act)) state_ff <= SPISD_RUN;
        SPISD_RUN:  if (!bus.enable) state_ff <= SPISD_IDLE;
                    else if (m_tick && edge_ff == `SPISD_LAST_EDGE) state_ff <= SPISD_FIN;
                    else if (!bus.master && !bus.ss_act) state_ff <= SPISD_IDLE;
        SPISD_FIN:  state_ff <= SPISD_IDLE;
        default:    state_ff <= SPISD_IDLE;
      endcase
    end
  end

  // Age of a running master byte, so that a hung byte is caught.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      age_ff <= 11'h000;
    end else if (state_ff != SPISD_IDLE && bus.master) begin
      age_ff <= age_ff + 11'h001;
    end else begin
      age_ff <= 11'h000;
    end
  end

  // Divider, edge counter and generated serial clock.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      div_ff   <= 7'h00;
      edge_ff  <= 5'h00;
      sck_ff   <= 1'b0;
      sck_d_ff <= 1'b0;
    end else begin
      sck_d_ff <= bus.sck_s;
      if (!run) begin
        div_ff  <= 7'h00;
        edge_ff <= 5'h00;
        sck_ff  <= bus.cpol;
      end else if (m_tick) begin
        div_ff  <= 7'h00;
        edge_ff <= edge_ff + 5'h01;
        sck_ff  <= ~sck_ff;
      end else begin
        div_ff  <= div_ff + 7'h01;
      end
    end
  end

  // Shift register, most significant bit out first, received bits enter at the bottom.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sh_ff   <= `SPISD_RST_BYTE;
      rx_ff   <= `SPISD_RST_BYTE;
      samp_ff <= 1'b0;
      sval_ff <= 1'b0;
      cnt_ff  <= 4'h0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= (m_tick && edge_ff == `SPISD_LAST_EDGE) || (s_chg && samp && cnt_ff == `SPISD_LAST_BIT);
      if (bus.load) begin
        sh_ff   <= bus.tx; // R10
        sval_ff <= 1'b0;
        cnt_ff  <= 4'h0;
      end else if (!run) begin
        sval_ff <= 1'b0;
        cnt_ff  <= 4'h0;
      end else if (samp) begin
        samp_ff <= bus.din;
        if (cnt_ff == `SPISD_LAST_BIT) begin
          rx_ff   <= {sh_ff[6:0], bus.din};
          cnt_ff  <= 4'h0;
          sval_ff <= 1'b0;
        end else begin
          cnt_ff  <= cnt_ff + 4'h1;
          sval_ff <= 1'b1;
        end
      end else if (shft && sval_ff) begin
        sh_ff   <= {sh_ff[6:0], samp_ff}; // R17
        sval_ff <= 1'b0;
      end
    end
  end

  // Answers toward the register side, all from flip-flops except busy.
  assign bus.sck_o = sck_ff;
  assign bus.dout  = sh_ff[7];
  assign bus.done  = done_ff;
  assign bus.rx    = rx_ff;
  assign bus.busy  = bus.master ? (state_ff != SPISD_IDLE) : (cnt_ff != 4'h0 || sval_ff);

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  a_load_direct: assert property (@(posedge clock) disable iff (!rstn) // R10
    bus.load |=> sh_ff == $past(bus.tx)) else $error("written byte not in shift register");
  a_msb_first: assert property (@(posedge clock) disable iff (!rstn) // R17
    (shft && sval_ff && !samp && !bus.load) |=> sh_ff[7] == $past(sh_ff[6])) else $error("shift order wrong");
  a_byte_bound: assert property (@(posedge clock) disable iff (!rstn) // R7
    age_ff <= `SPISD_BYTE_LIMIT) else $error("master byte did not end in time");
  c_master_byte: cover property (@(posedge clock) disable iff (!rstn) state_ff == SPISD_FIN);

endmodule // spisd_shift

// [tb/spisd_peer.sv]
`timescale 1ns/1ps

module spisd_peer (
  // Serial pins.
  input  wire logic       rstn,
  input  wire logic       sck,
  input  wire logic       mosi,
  output logic            miso,
  // Bench side.
  input  wire logic [7:0] reply,
  output logic [7:0]      got,
  output logic [3:0]      bytes
);
  logic [7:0] sh;
  logic [2:0] cnt;

  // Captures one bit per rising edge and counts whole bytes.
  always @(posedge sck or negedge rstn) begin
    if (!rstn) begin
      cnt   <= 3'h0;
      got   <= 8'h00;
      bytes <= 4'h0;
    end else begin
      got <= {got[6:0], mosi};
      cnt <= cnt + 3'h1;
      if (cnt == 3'h7) begin
        bytes <= bytes + 4'h1;
      end
    end
  end

  // Shifts on falling edges; garbage enters below so stale bits never repeat.
  always @(negedge sck or negedge rstn) begin
    if (!rstn || cnt == 3'h0) begin
      sh <= reply;
    end else begin
      sh <= {sh[6:0], ~sh[7]};
    end
  end
  assign miso = sh[7];
endmodule // spisd_peer

// [tb/test_spisd_top.sv]
`timescale 1ns/1ps
`include "spisd_defines.svh"

module test_spisd_top;
  import spisd_pkg::*;
  // ---------------------------------------------------------------------------
  // Signals and instances
  // ---------------------------------------------------------------------------
  logic        clock = 1'b0;
  logic        rstn = 1'b1;
  logic        sck_pin = 1'b0;
  logic        mosi_pin = 1'b0;
  logic [7:0]  addr = 8'h00;
  spisd_byte_t wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        ss_in_n = 1'b1;
  spisd_byte_t rdata;
  logic        sck_out, sck_oe, mosi_out, mosi_oe, miso_line, miso_out, miso_oe, irq;
  logic [7:0]  got;
  logic [3:0]  bytes;
  int          bad_count = 0;
  int          num_checks = 0;

  // Free running 100 MHz clock.
  always #5 clock = ~clock;

  spisd_top dut_u (.clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .sck_in(sck_pin), .sck_out(sck_out), .sck_oe(sck_oe), .mosi_in(mosi_pin),
    .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_line), .miso_out(miso_out), .miso_oe(miso_oe),
    .ss_in_n(ss_in_n), .irq(irq));
  spisd_peer peer_u (.rstn(rstn), .sck(sck_out), .mosi(mosi_out), .miso(miso_line),
    .reply(8'ha5), .got(got), .bytes(bytes));

  // Compares and reports one value.
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    num_checks++;
    if (seen !== want) begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr    <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] want);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd   <= 1'b0;
    #1;
    check(rdata, want);
  endtask
  task automatic finish_test;
    if (bad_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset;
    rchk(`SPISD_ADR_CTRL, 8'h00);
    rchk(`SPISD_ADR_CSR, 8'h00);
    rchk(`SPISD_ADR_IRQMK, 8'h07);
    rchk(8'h30, 8'h00);
  endtask
  // Master byte at /16, then a write while done is still standing.
  task automatic t_xfer;
    wreg(`SPISD_ADR_CTRL, 8'hd1);
    wreg(`SPISD_ADR_DATA, 8'h3c);
    #1;
    check({6'h0, sck_oe, mosi_oe}, 8'h03);
    for (int i = 0; i < 300 && irq !== 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    check({7'h0, irq}, 8'h01);
    check(got, 8'h3c);
    wreg(`SPISD_ADR_DATA, 8'h77);
    repeat (100) @(posedge clock);
    check({4'h0, bytes}, 8'h01);
    rchk(`SPISD_ADR_CSR, 8'h80);
    rchk(`SPISD_ADR_DATA, 8'ha5);
    rchk(`SPISD_ADR_CSR, 8'h00);
    wreg(`SPISD_ADR_IRQST, 8'h07);
    @(posedge clock);
    #1;
    check({7'h0, irq}, 8'h00);
  endtask
  // Select pin pulled low while master.
  task automatic t_fault;
    wreg(`SPISD_ADR_CTRL, 8'h50);
    ss_in_n <= 1'b0;
    repeat (6) @(posedge clock);
    rchk(`SPISD_ADR_CSR, 8'h10);
    rchk(`SPISD_ADR_CTRL, 8'h00);
    ss_in_n <= 1'b1;
    wreg(`SPISD_ADR_CTRL, 8'h00);
    rchk(`SPISD_ADR_CSR, 8'h00);
  endtask
  // Software select, output disable and soft select fault.
  task automatic t_soft;
    wreg(`SPISD_ADR_CSR, 8'h03);
    wreg(`SPISD_ADR_CTRL, 8'h50);
    ss_in_n <= 1'b0;
    repeat (6) @(posedge clock);
    rchk(`SPISD_ADR_CSR, 8'h03);
    check({7'h0, mosi_oe}, 8'h01);
    wreg(`SPISD_ADR_CSR, 8'h07);
    repeat (2) @(posedge clock);
    #1;
    check({7'h0, mosi_oe}, 8'h00);
    wreg(`SPISD_ADR_CSR, 8'h02);
    repeat (6) @(posedge clock);
    rchk(`SPISD_ADR_CSR, 8'h12);
    ss_in_n <= 1'b1;
  endtask
  // Slave byte clocked by the bench at 160 ns, checked in both directions.
  task automatic t_slave;
    logic [7:0] seen;
    logic [7:0] sent = 8'h5a;
    wreg(`SPISD_ADR_CSR, 8'h00);
    wreg(`SPISD_ADR_CTRL, 8'h40);
    wreg(`SPISD_ADR_DATA, 8'h96);
    ss_in_n <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      mosi_pin <= sent[i];
      repeat (8) @(posedge clock);
      seen[i] = miso_out;
      sck_pin <= 1'b1;
      repeat (8) @(posedge clock);
      sck_pin <= 1'b0;
    end
    repeat (4) @(posedge clock);
    ss_in_n <= 1'b1;
    #1;
    check({7'h0, miso_oe}, 8'h01);
    check(seen, 8'h96);
    rchk(`SPISD_ADR_DATA, 8'h5a);
  endtask

  // Main sequence.
  initial begin
    rstn <= 1'b0;
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    t_reset;
    t_xfer;
    t_fault;
    t_soft;
    t_slave;
    finish_test;
  end
  // Watchdog against a hang.
  initial begin
    #100us;
    bad_count++;
    finish_test;
  end
endmodule // test_spisd_top
